// ==== idt_cfg.svh ====
// Register offsets, field positions and constants of the dual IR timer block.
`ifndef IDT_CFG_SVH
`define IDT_CFG_SVH

`define IDT_A_NCTL     8'h00
`define IDT_A_MODE     8'h01
`define IDT_A_WCTL     8'h02
`define IDT_A_SYNC     8'h03
`define IDT_A_NHI      8'h04
`define IDT_A_NLO      8'h05
`define IDT_A_WHI      8'h06
`define IDT_A_WLO      8'h07
`define IDT_A_CHI      8'h08
`define IDT_A_CLO      8'h09

`define IDT_B_EN       7
`define IDT_B_SINGLE   6
`define IDT_B_TOUT     5
`define IDT_B_CLK_HI   4
`define IDT_B_CLK_LO   3
`define IDT_B_CAPM     2
`define IDT_B_TOM      1
`define IDT_B_OSEL     0
`define IDT_B_NEN      6
`define IDT_B_SYNC     5
`define IDT_B_INSEL    6
`define IDT_B_FALL     5
`define IDT_B_RISE     4
`define IDT_B_DEMOD    3
`define IDT_B_PP       2
`define IDT_B_INIT     1
`define IDT_B_ESTAT    0

`define IDT_BYTE_ZERO  8'h00
`define IDT_WORD_ZERO  16'h0000
`define IDT_N_TERM     8'h01
`define IDT_W_TERM     16'h0001
`define IDT_W_ONES     16'hFFFF
`define IDT_PRE_ZERO   3'h0
`define IDT_PRE_STEP   3'h1
`define IDT_MASK_DIV1  3'h0
`define IDT_MASK_DIV2  3'h1
`define IDT_MASK_DIV4  3'h3
`define IDT_MASK_DIV8  3'h7

`endif

// ==== idt_pkg.sv ====
// Types shared by the dual IR timer block.
package idt_pkg;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } idt_bus_req_t;

    typedef enum logic [1:0] {
        IDT_W_IDLE = 2'b00,
        IDT_W_RUN  = 2'b01,
        IDT_W_ARM  = 2'b10
    } idt_wstate_t;

    typedef enum logic [1:0] {
        IDT_DIV_1 = 2'b00,
        IDT_DIV_2 = 2'b01,
        IDT_DIV_4 = 2'b10,
        IDT_DIV_8 = 2'b11
    } idt_clk_sel_t;

endpackage

// ==== idt_timers.sv ====
// Dual down-counter IR timer block: narrow carrier timer and wide capture timer.
`timescale 1ns/1ps
`default_nettype none
`include "idt_cfg.svh"

module idt_timers (
    input  wire logic                  clock_in,
    input  wire logic                  rst_n_in,
    input  wire logic                  ce_in,
    input  wire idt_pkg::idt_bus_req_t bus_in,
    output var  logic [7:0]            rd_data_out,
    input  wire logic                  stop_recover_in,
    input  wire logic                  port3_edge_input_in,
    input  wire logic                  port2_edge_input_in,
    input  wire logic                  port_latch_in,
    output var  logic                  shared_output_pin_out,
    output var  logic                  narrow_output_out,
    output var  logic                  narrow_irq_out,
    output var  logic                  wide_timeout_irq_out,
    output var  logic                  capture_irq_out
);
    import idt_pkg::*;

    function automatic logic wr_hit(input idt_bus_req_t r, input logic [7:0] a);
        return r.wr && (r.addr == a);
    endfunction

    // Software control fields.
    logic                  n_single_r;
    logic                  n_tout_r;
    logic                  n_mask_r;
    logic                  in_sel_r;
    logic                  fall_sel_r;
    logic                  rise_sel_r;
    logic                  demod_r;
    logic                  pingpong_r;
    logic                  init_lvl_r;
    logic                  edge_stat_r;
    logic                  w_single_r;
    logic                  w_tout_r;
    idt_clk_sel_t          clk_sel_r;
    logic                  cap_mask_r;
    logic                  tout_mask_r;
    logic                  out_sel_r;
    logic                  sync_mode_r;
    logic [7:0]            n_high_r;
    logic [7:0]            n_low_r;
    logic [7:0]            w_high_r;
    logic [7:0]            w_low_r;
    logic [7:0]            cap_high_r;
    logic [7:0]            cap_low_r;

    // Timer state.
    logic                  n_run_r;
    logic [7:0]            n_cnt_r;
    logic                  n_out_r;
    idt_wstate_t           w_state_r;
    logic [15:0]           w_cnt_r;
    logic                  w_out_r;
    logic [2:0]            presc_r;
    logic                  edge_prev_r;

    logic [7:0]            wd;
    logic                  wr_nctl;
    logic                  wr_mode;
    logic                  wr_wctl;
    logic                  wr_sync;
    logic                  sync_go;
    logic                  w_set;
    logic                  w_clr;
    logic                  n_set;
    logic                  n_clr;
    logic                  w_stopping;
    logic                  n_stopping;
    logic                  w_run;
    logic [2:0]            tick_mask;
    logic                  tick;
    logic                  edge_in;
    logic                  edge_hit;
    logic                  cap_now;
    logic                  w_term;
    logic                  n_term;
    logic                  n_done;
    logic                  pp_start_w;
    logic                  pp_start_n;
    logic [7:0]            rd_val;

    assign wd      = bus_in.wdata;
    assign wr_nctl = wr_hit(bus_in, `IDT_A_NCTL);
    assign wr_mode = wr_hit(bus_in, `IDT_A_MODE);
    assign wr_wctl = wr_hit(bus_in, `IDT_A_WCTL);
    assign wr_sync = wr_hit(bus_in, `IDT_A_SYNC);
    assign w_run   = (w_state_r != IDT_W_IDLE);

    // In sync mode one write to the sync register that enables either timer starts both on the same edge.
    assign sync_go = wr_sync && sync_mode_r && (wd[`IDT_B_EN] || wd[`IDT_B_NEN]);

    assign w_set = (wr_wctl && wd[`IDT_B_EN]) || (wr_sync && wd[`IDT_B_EN])
                   || sync_go || pp_start_w;
    assign w_clr = (wr_wctl && !wd[`IDT_B_EN]) || (wr_sync && !wd[`IDT_B_EN] && !sync_go);
    assign n_set = (wr_nctl && wd[`IDT_B_EN]) || (wr_sync && wd[`IDT_B_NEN])
                   || sync_go || pp_start_n;
    assign n_clr = (wr_nctl && !wd[`IDT_B_EN]) || (wr_sync && !wd[`IDT_B_NEN] && !sync_go);

    assign w_stopping = stop_recover_in || (w_clr && !w_set);
    assign n_stopping = stop_recover_in || (n_clr && !n_set);

    always_comb
    begin
        unique case (clk_sel_r)
            IDT_DIV_1: tick_mask = `IDT_MASK_DIV1;
            IDT_DIV_2: tick_mask = `IDT_MASK_DIV2;
            IDT_DIV_4: tick_mask = `IDT_MASK_DIV4;
            IDT_DIV_8: tick_mask = `IDT_MASK_DIV8;
        endcase
    end

    assign tick = ((presc_r & tick_mask) == tick_mask);

    assign edge_in  = in_sel_r ? port2_edge_input_in : port3_edge_input_in;
    assign edge_hit = (rise_sel_r && edge_in && !edge_prev_r)
                      || (fall_sel_r && !edge_in && edge_prev_r);

    // A later edge is ignored in single-pass demodulation.
    assign cap_now = demod_r && edge_hit && !w_stopping
                     && ((w_state_r == IDT_W_ARM)
                         || ((w_state_r == IDT_W_RUN) && !w_single_r));

    // Terminal count is the step from one to zero; zero itself wraps silently.
    assign w_term = (w_state_r == IDT_W_RUN) && tick && (w_cnt_r == `IDT_W_TERM)
                    && !cap_now && !w_stopping;
    assign n_term = n_run_r && (n_cnt_r == `IDT_N_TERM) && !n_stopping;

    // A modulo-N cycle is complete when the output returns to its initial level.
    assign n_done = n_term && (n_single_r || (n_out_r != init_lvl_r));

    assign pp_start_w = pingpong_r && n_term && n_single_r;
    assign pp_start_n = pingpong_r && w_term && w_single_r && !demod_r;

    always_ff @(posedge clock_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            presc_r     <= `IDT_PRE_ZERO;
            edge_prev_r <= 1'h0;
        end
        else if (ce_in)
        begin
            presc_r     <= presc_r + `IDT_PRE_STEP;
            edge_prev_r <= edge_in;
        end
    end

    // Power-on only fields survive stop-mode recovery.
    always_ff @(posedge clock_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            clk_sel_r   <= IDT_DIV_1;
            cap_mask_r  <= 1'h0;
            sync_mode_r <= 1'h0;
        end
        else if (ce_in)
        begin
            if (wr_wctl)
            begin
                clk_sel_r  <= idt_clk_sel_t'(wd[`IDT_B_CLK_HI:`IDT_B_CLK_LO]);
                cap_mask_r <= wd[`IDT_B_CAPM];
            end
            if (wr_sync)
            begin
                sync_mode_r <= wd[`IDT_B_SYNC];
            end
        end
    end

    always_ff @(posedge clock_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            n_single_r  <= 1'h0;
            n_mask_r    <= 1'h0;
            in_sel_r    <= 1'h0;
            fall_sel_r  <= 1'h0;
            rise_sel_r  <= 1'h0;
            demod_r     <= 1'h0;
            pingpong_r  <= 1'h0;
            init_lvl_r  <= 1'h0;
            w_single_r  <= 1'h0;
            tout_mask_r <= 1'h0;
            out_sel_r   <= 1'h0;
        end
        else if (ce_in)
        begin
            if (stop_recover_in)
            begin
                n_single_r  <= 1'h0;
                n_mask_r    <= 1'h0;
                in_sel_r    <= 1'h0;
                fall_sel_r  <= 1'h0;
                rise_sel_r  <= 1'h0;
                demod_r     <= 1'h0;
                pingpong_r  <= 1'h0;
                init_lvl_r  <= 1'h0;
                w_single_r  <= 1'h0;
                tout_mask_r <= 1'h0;
                out_sel_r   <= 1'h0;
            end
            else
            begin
                if (wr_nctl)
                begin
                    n_single_r <= wd[`IDT_B_SINGLE];
                    n_mask_r   <= wd[`IDT_B_TOM];
                end
                if (wr_mode)
                begin
                    in_sel_r   <= wd[`IDT_B_INSEL];
                    fall_sel_r <= wd[`IDT_B_FALL];
                    rise_sel_r <= wd[`IDT_B_RISE];
                    demod_r    <= wd[`IDT_B_DEMOD];
                    pingpong_r <= wd[`IDT_B_PP];
                    init_lvl_r <= wd[`IDT_B_INIT];
                end
                if (wr_wctl)
                begin
                    w_single_r  <= wd[`IDT_B_SINGLE];
                    tout_mask_r <= wd[`IDT_B_TOM];
                    out_sel_r   <= wd[`IDT_B_OSEL];
                end
            end
        end
    end

    // Hardware set wins over a same-cycle write-one clear.
    always_ff @(posedge clock_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            w_tout_r    <= 1'h0;
            n_tout_r    <= 1'h0;
            edge_stat_r <= 1'h0;
        end
        else if (ce_in)
        begin
            w_tout_r <= w_term || (w_tout_r && !stop_recover_in
                                   && !(wr_wctl && wd[`IDT_B_TOUT]));
            n_tout_r <= n_done || (n_tout_r && !stop_recover_in
                                   && !(wr_nctl && wd[`IDT_B_TOUT]));
            edge_stat_r <= (cap_now && (w_state_r == IDT_W_RUN))
                           || (edge_stat_r && !stop_recover_in
                               && !(wr_mode && wd[`IDT_B_ESTAT]));
        end
    end

    always_ff @(posedge clock_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            n_high_r <= `IDT_BYTE_ZERO;
            n_low_r  <= `IDT_BYTE_ZERO;
            w_high_r <= `IDT_BYTE_ZERO;
            w_low_r  <= `IDT_BYTE_ZERO;
        end
        else if (ce_in)
        begin
            // Only the staging registers change; counters pick them up at load.
            if (wr_hit(bus_in, `IDT_A_NHI)) n_high_r <= wd;
            if (wr_hit(bus_in, `IDT_A_NLO)) n_low_r  <= wd;
            if (wr_hit(bus_in, `IDT_A_WHI)) w_high_r <= wd;
            if (wr_hit(bus_in, `IDT_A_WLO)) w_low_r  <= wd;
        end
    end

    always_ff @(posedge clock_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            cap_high_r <= `IDT_BYTE_ZERO;
            cap_low_r  <= `IDT_BYTE_ZERO;
        end
        else if (ce_in && cap_now)
        begin
            {cap_high_r, cap_low_r} <= ~w_cnt_r;
        end
    end

    always_ff @(posedge clock_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            w_state_r <= IDT_W_IDLE;
            w_cnt_r   <= `IDT_WORD_ZERO;
            w_out_r   <= 1'h0;
        end
        else if (ce_in)
        begin
            if (w_stopping)
            begin
                w_state_r <= IDT_W_IDLE;
            end
            else if ((w_state_r == IDT_W_IDLE) && w_set)
            begin
                w_state_r <= demod_r ? IDT_W_ARM : IDT_W_RUN;
                w_cnt_r   <= {w_high_r, w_low_r};
            end
            else
            begin
                unique case (w_state_r)
                    IDT_W_IDLE: ;
                    IDT_W_ARM:
                        if (cap_now)
                        begin
                            w_state_r <= IDT_W_RUN;
                            w_cnt_r   <= `IDT_W_ONES;
                        end
                    IDT_W_RUN:
                        if (cap_now)
                        begin
                            w_cnt_r <= `IDT_W_ONES;
                        end
                        else if (w_term)
                        begin
                            w_out_r <= !w_out_r;
                            if (demod_r)
                            begin
                                w_cnt_r <= `IDT_W_ONES;
                            end
                            else if (w_single_r)
                            begin
                                w_state_r <= IDT_W_IDLE;
                            end
                            else
                            begin
                                w_cnt_r <= {w_high_r, w_low_r};
                            end
                        end
                        else if (tick)
                        begin
                            w_cnt_r <= w_cnt_r - `IDT_W_TERM;
                        end
                    default: w_state_r <= IDT_W_IDLE;
                endcase
            end
        end
    end

    always_ff @(posedge clock_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            n_run_r <= 1'h0;
            n_cnt_r <= `IDT_BYTE_ZERO;
            n_out_r <= 1'h0;
        end
        else if (ce_in)
        begin
            if (n_stopping)
            begin
                n_run_r <= 1'h0;
            end
            else if (!n_run_r && n_set)
            begin
                n_run_r <= 1'h1;
                n_out_r <= init_lvl_r;
                n_cnt_r <= init_lvl_r ? n_high_r : n_low_r;
            end
            else if (n_term)
            begin
                n_out_r <= !n_out_r;
                if (n_single_r)
                begin
                    n_run_r <= 1'h0;
                end
                else
                begin
                    // The new level is the inverse of the current one.
                    n_cnt_r <= n_out_r ? n_low_r : n_high_r;
                end
            end
            else if (n_run_r)
            begin
                n_cnt_r <= n_cnt_r - `IDT_N_TERM;
            end
        end
    end

    always_ff @(posedge clock_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            narrow_irq_out       <= 1'h0;
            wide_timeout_irq_out <= 1'h0;
            capture_irq_out      <= 1'h0;
        end
        else if (ce_in)
        begin
            narrow_irq_out       <= n_done && n_mask_r;
            wide_timeout_irq_out <= w_term && tout_mask_r;
            capture_irq_out      <= cap_now && cap_mask_r;
        end
    end

    always_ff @(posedge clock_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            shared_output_pin_out <= 1'h0;
            narrow_output_out     <= 1'h0;
        end
        else if (ce_in)
        begin
            shared_output_pin_out <= out_sel_r ? w_out_r : port_latch_in;
            narrow_output_out     <= n_out_r;
        end
    end

    always_comb
    begin
        rd_val = `IDT_BYTE_ZERO;
        unique case (bus_in.addr)
            `IDT_A_NCTL:
            begin
                rd_val[`IDT_B_EN]     = n_run_r;
                rd_val[`IDT_B_SINGLE] = n_single_r;
                rd_val[`IDT_B_TOUT]   = n_tout_r;
                rd_val[`IDT_B_TOM]    = n_mask_r;
            end
            `IDT_A_MODE:
            begin
                rd_val[`IDT_B_INSEL] = in_sel_r;
                rd_val[`IDT_B_FALL]  = fall_sel_r;
                rd_val[`IDT_B_RISE]  = rise_sel_r;
                rd_val[`IDT_B_DEMOD] = demod_r;
                rd_val[`IDT_B_PP]    = pingpong_r;
                rd_val[`IDT_B_INIT]  = init_lvl_r;
                rd_val[`IDT_B_ESTAT] = edge_stat_r;
            end
            `IDT_A_WCTL:
            begin
                rd_val[`IDT_B_EN]                   = w_run;
                rd_val[`IDT_B_SINGLE]               = w_single_r;
                rd_val[`IDT_B_TOUT]                 = w_tout_r;
                rd_val[`IDT_B_CLK_HI:`IDT_B_CLK_LO] = clk_sel_r;
                rd_val[`IDT_B_CAPM]                 = cap_mask_r;
                rd_val[`IDT_B_TOM]                  = tout_mask_r;
                rd_val[`IDT_B_OSEL]                 = out_sel_r;
            end
            `IDT_A_SYNC:
            begin
                rd_val[`IDT_B_EN]   = w_run;
                rd_val[`IDT_B_NEN]  = n_run_r;
                rd_val[`IDT_B_SYNC] = sync_mode_r;
            end
            `IDT_A_NHI: rd_val = n_high_r;
            `IDT_A_NLO: rd_val = n_low_r;
            `IDT_A_WHI: rd_val = w_high_r;
            `IDT_A_WLO: rd_val = w_low_r;
            `IDT_A_CHI: rd_val = cap_high_r;
            `IDT_A_CLO: rd_val = cap_low_r;
            default:    rd_val = `IDT_BYTE_ZERO;
        endcase
    end

    // Read data stands for exactly the cycle after the strobe, zero otherwise.
    always_ff @(posedge clock_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            rd_data_out <= `IDT_BYTE_ZERO;
        end
        else if (ce_in)
        begin
            rd_data_out <= bus_in.rd ? rd_val : `IDT_BYTE_ZERO;
        end
    end

endmodule // idt_timers

`default_nettype wire

// ==== idt_timers_assertions.sv ====
// Checker of the dual IR timer block's port behaviour, bound to the block.
`timescale 1ns/1ps
`default_nettype none
module idt_timers_chk (
    input  wire logic                  clock_in,
    input  wire logic                  rst_n_in,
    input  wire logic                  ce_in,
    input  wire idt_pkg::idt_bus_req_t bus_in,
    input  wire logic [7:0]            rd_data_out,
    input  wire logic                  stop_recover_in,
    input  wire logic                  port_latch_in,
    input  wire logic                  shared_output_pin_out,
    input  wire logic                  narrow_output_out,
    input  wire logic                  narrow_irq_out,
    input  wire logic                  wide_timeout_irq_out,
    input  wire logic                  capture_irq_out
);
    import idt_pkg::*;
    logic osel_r, tom_r, capm_r, nmsk_r;
    default clocking @(posedge clock_in); endclocking
    default disable iff (!rst_n_in);
    // Shadows of the routing and mask bits, so each output can be tied to its enable.
    always_ff @(posedge clock_in or negedge rst_n_in)
        if (!rst_n_in)
            {osel_r, tom_r, capm_r} <= 3'h0;
        else if (ce_in && bus_in.wr && bus_in.addr == 8'h02)
            {osel_r, tom_r, capm_r} <= {bus_in.wdata[0], bus_in.wdata[1], bus_in.wdata[2]};
        else if (ce_in && stop_recover_in)
            {osel_r, tom_r} <= 2'h0;
    always_ff @(posedge clock_in or negedge rst_n_in)
        if (!rst_n_in)
            nmsk_r <= 1'b0;
        else if (ce_in && bus_in.wr && bus_in.addr == 8'h00)
            nmsk_r <= bus_in.wdata[1];
        else if (ce_in && stop_recover_in)
            nmsk_r <= 1'b0;
    a_rd_data_quiet: assert property (rd_data_out != 8'h00 |-> $past(bus_in.rd && ce_in))
        else $error("read data outside a read answer");
    a_rd_unmapped_zero: assert property (bus_in.rd && ce_in && bus_in.addr > 8'h09 |=>
        rd_data_out == 8'h00) else $error("unmapped read not zero");
    a_pin_follows_latch: assert property (!osel_r && $past(!osel_r) && $past(rst_n_in)
        |-> shared_output_pin_out == $past(port_latch_in)) else $error("pin not port latch");
    a_wide_irq_mask: assert property (wide_timeout_irq_out |-> $past(tom_r) || $past(tom_r, 2))
        else $error("timeout irq while masked");
    a_cap_irq_mask: assert property (capture_irq_out |-> $past(capm_r) || $past(capm_r, 2))
        else $error("capture irq while masked");
    a_narrow_irq_mask: assert property (narrow_irq_out |-> $past(nmsk_r) || $past(nmsk_r, 2))
        else $error("narrow irq while masked");
    a_wide_irq_pulse: assert property (wide_timeout_irq_out |=> !wide_timeout_irq_out)
        else $error("timeout irq longer than one cycle");
    a_cap_irq_pulse: assert property (capture_irq_out |=> !capture_irq_out)
        else $error("capture irq longer than one cycle");
    a_narrow_irq_toggle: assert property (narrow_irq_out |=> $changed(narrow_output_out))
        else $error("narrow irq without output toggle");
endmodule // idt_timers_chk
bind idt_timers idt_timers_chk u_chk (.clock_in(clock_in), .rst_n_in(rst_n_in), .ce_in(ce_in),
    .bus_in(bus_in), .rd_data_out(rd_data_out), .stop_recover_in(stop_recover_in),
    .port_latch_in(port_latch_in), .shared_output_pin_out(shared_output_pin_out),
    .narrow_output_out(narrow_output_out), .narrow_irq_out(narrow_irq_out),
    .wide_timeout_irq_out(wide_timeout_irq_out), .capture_irq_out(capture_irq_out));
`default_nettype wire

// ==== idt_edge_src.sv ====
// Far-side model that makes edges on the two edge-detect input pins.
`timescale 1ns/1ps
`default_nettype none
module idt_edge_src (
    input  wire logic clock_in,
    input  wire logic rst_n_in,
    input  wire logic go_in,
    input  wire logic sel_in,
    output var  logic port3_out,
    output var  logic port2_out
);
    // Each request flips one pin, so rising and falling edges alternate on it.
    always_ff @(posedge clock_in or negedge rst_n_in)
        if (!rst_n_in)
            {port3_out, port2_out} <= 2'h0;
        else if (go_in)
            {port3_out, port2_out} <= {port3_out ^ !sel_in, port2_out ^ sel_in};
endmodule // idt_edge_src
`default_nettype wire

// ==== tb_top.sv ====
// Self-checking bench of the dual IR timer block.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import idt_pkg::*;
    logic         clock_in, rst_n_in, srec, latch, go, sel, p3, p2, pin, nout, nirq, wirq, cirq;
    logic [7:0]   d, h, l;
    logic [7:0]   nv [3];
    idt_bus_req_t bus;
    int           n_errors, compares, n, k, x, y;
    idt_timers uut (.clock_in(clock_in), .rst_n_in(rst_n_in), .ce_in(1'b1), .bus_in(bus),
        .rd_data_out(d), .stop_recover_in(srec), .port3_edge_input_in(p3),
        .port2_edge_input_in(p2), .port_latch_in(latch), .shared_output_pin_out(pin),
        .narrow_output_out(nout), .narrow_irq_out(nirq), .wide_timeout_irq_out(wirq),
        .capture_irq_out(cirq));
    idt_edge_src u_src (.clock_in(clock_in), .rst_n_in(rst_n_in), .go_in(go), .sel_in(sel),
        .port3_out(p3), .port2_out(p2));
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge clock_in);
        bus <= '{a, v, 1'b1, 1'b0};
        @(posedge clock_in);
        bus.wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] v);
        @(posedge clock_in);
        bus <= '{a, 8'h00, 1'b0, 1'b1};
        @(posedge clock_in);
        bus.rd <= 1'b0;
        @(negedge clock_in);
        v = d;
    endtask
    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] s);
        compares++;
        if (s !== e)
        begin
            n_errors++;
            $display("BAD %s expected %h seen %h", nm, e, s);
        end
    endtask
    task automatic wt(ref logic s, input int lim, output int c);
        c = 0;
        do
        begin
            @(posedge clock_in);
            #1;
            c++;
        end while (s !== 1'b1 && c < lim);
    endtask
    task automatic pulse(input logic s);
        @(posedge clock_in);
        {go, sel} <= {1'b1, s};
        @(posedge clock_in);
        go <= 1'b0;
    endtask
    task automatic close_out;
        $display("compares %0d n_errors %0d", compares, n_errors);
        if (n_errors == 0 && compares > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    initial
    begin
        clock_in = 1'b0;
        forever #10 clock_in = ~clock_in;
    end
    initial
    begin
        #400000;
        n_errors++;
        close_out();
    end
    initial
    begin
        {rst_n_in, srec, latch, go, sel, bus} = '0;
        void'($urandom(32'h9FC9EE5D));
        repeat (10) @(posedge clock_in);
        rst_n_in <= 1'b1;
        rd(8'h02, h); chk("wide_ctrl", 8'h00, h);
        rd(8'h03, h); chk("sync_ctrl", 8'h00, h);
        wr(8'h0A, 8'h5A); rd(8'h0A, h); chk("unmapped", 8'h00, h);
        for (k = 0; k < 4; k++)
        begin
            @(posedge clock_in);
            latch <= 1'($urandom);
            repeat (2) @(posedge clock_in);
            #1 chk("pin", latch, pin);
        end
        $display("test registers done");
        nv = '{8'h00, 8'h04, 8'h03 + 8'($urandom % 40)};
        foreach (nv[i])
        begin
            wr(8'h01, 8'h00); wr(8'h05, nv[i]); wr(8'h00, 8'hC2);
            wr(8'h05, 8'h07);
            wt(nirq, 400, n); chk("narrow_len", (nv[i] == 0 ? 256 : nv[i]) - 2, n);
            rd(8'h00, h); chk("narrow_ctrl", 8'h62, h); chk("narrow_out", 1, nout);
            wr(8'h00, 8'h20);
        end
        x = 2 + $urandom % 16;
        y = 2 + $urandom % 16;
        wr(8'h04, 8'(y)); wr(8'h05, 8'(x)); wr(8'h00, 8'h82);
        wt(nirq, 100, n); wt(nirq, 100, n); chk("modulo_period", x + y, n);
        wr(8'h00, 8'h20);
        $display("test narrow done");
        for (k = 0; k < 4; k++)
        begin
            x = 2 + $urandom % 6;
            wr(8'h06, 8'h00); wr(8'h07, 8'(x)); wr(8'h02, {3'b100, k[1:0], 3'b010});
            wt(wirq, 200, n); wt(wirq, 200, n); chk("wide_period", x << k, n);
            wr(8'h02, 8'h20);
        end
        wr(8'h02, 8'hC2); wt(wirq, 200, n); chk("wide_irq", 1, wirq);
        rd(8'h02, h); chk("wide_single", 8'h62, h);
        wr(8'h02, 8'h20); rd(8'h02, h); chk("wide_w1c", 8'h00, h);
        $display("test wide done");
        wr(8'h01, 8'h18); wr(8'h06, 8'hFF); wr(8'h07, 8'hFF); wr(8'h02, 8'h84);
        pulse(0); repeat (10) @(posedge clock_in);
        pulse(0); repeat (10) @(posedge clock_in);
        pulse(0); wt(cirq, 20, n); chk("cap_irq", 1, cirq);
        rd(8'h08, h); rd(8'h09, l); chk("capture", 16'h0017, {h, l});
        rd(8'h01, h); chk("edge_status", 8'h19, h);
        wr(8'h01, 8'h59); wr(8'h02, 8'h00); wr(8'h02, 8'hC4);
        pulse(1); wt(cirq, 20, n); chk("port2_edge", 1, cirq);
        pulse(1); pulse(1); wt(cirq, 20, n); chk("later_edge", 0, cirq);
        $display("test demodulation done");
        wr(8'h01, 8'h00); wr(8'h02, 8'h9F); rd(8'h02, h); chk("wide_run", 8'h9F, h);
        wr(8'h03, 8'h20);
        @(posedge clock_in);
        srec <= 1'b1;
        @(posedge clock_in);
        srec <= 1'b0;
        rd(8'h02, h); chk("recover_wide", 8'h1C, h);
        rd(8'h03, h); chk("recover_sync", 8'h20, h);
        wr(8'h03, 8'hA0); rd(8'h03, h); chk("sync_start", 8'hE0, h);
        wr(8'h03, 8'h00);
        $display("test recovery done");
        wr(8'h00, 8'h42); wr(8'h02, 8'h42); wr(8'h01, 8'h04);
        wr(8'h06, 8'h00); wr(8'h07, 8'h03); wr(8'h05, 8'(y));
        wr(8'h00, 8'hC2);
        wt(wirq, 100, n); chk("pp_wide", y + 3, n);
        wt(nirq, 100, n); chk("pp_narrow", y, n);
        wr(8'h01, 8'h00); wr(8'h00, 8'h20); wr(8'h02, 8'h20);
        $display("test ping-pong done");
        close_out();
    end
endmodule // tb_top
`default_nettype wire
